//--- hdl/sdram_bank_command_legality.sv
// Command decode, device-wide states and legality check of a four-bank SDRAM
`timescale 1ns/1ps
module sdram_bank_command_legality #(
  parameter int ACT_CYC   = sdram_legality_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC,
  parameter int PRE_CYC   = sdram_legality_pkg::PRECHARGE_PERIOD_CYC,
  parameter int REF_CYC   = sdram_legality_pkg::REFRESH_CYCLE_CYC,
  parameter int MRD_CYC   = sdram_legality_pkg::MODE_REGISTER_DELAY_CYC,
  parameter int XSR_CYC   = sdram_legality_pkg::SELF_REFRESH_EXIT_TIME_CYC,
  parameter int BURST_LEN = sdram_legality_pkg::BURST_LEN_DEFAULT
) (
  input  wire logic                            i_clock,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_clk_en,
  input  wire logic                            i_cke,
  input  wire sdram_legality_pkg::cmd_pins_t   i_cmd,
  output sdram_legality_pkg::bank_state_t      o_bank_state [sdram_legality_pkg::NUM_BANKS],
  output sdram_legality_pkg::cmd_t             o_cmd,
  output logic                                 o_all_idle,
  output logic                                 o_device_busy,
  output logic                                 o_rules_active,
  output logic                                 o_violation
);
  import sdram_legality_pkg::*;

  if (REF_CYC < 2 || REF_CYC > 255 || MRD_CYC < 1 || MRD_CYC > 255 ||
      XSR_CYC < 1 || XSR_CYC > 255 || PRE_CYC < 1 || PRE_CYC > 255)
  begin : g_bad_param
    $error("Device counts must lie in range, refresh at least 2");
  end

  localparam logic [CNT_W-1:0] REF_LOAD = CNT_W'(REF_CYC - 1);
  localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(MRD_CYC - 1);
  localparam logic [CNT_W-1:0] XSR_LOAD = CNT_W'(XSR_CYC - 1);
  localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(PRE_CYC - 1);

  logic             cke_prev;
  dev_state_t       dev_state;
  dev_state_t       next_dev_state;
  logic [CNT_W-1:0] dev_cnt;
  logic [CNT_W-1:0] next_dev_cnt;
  logic [BANK_W-1:0] last_bank;

  // Command decode from select and the three strobes
  wire [2:0] strobes = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
  wire cmd_t dec_cmd =
    i_cmd.cs_n          ? CMD_INHIBIT :
    (strobes == 3'h7)   ? CMD_NOP :
    (strobes == 3'h3)   ? CMD_ACTIVATE :
    (strobes == 3'h5)   ? CMD_READ :
    (strobes == 3'h4)   ? CMD_WRITE :
    (strobes == 3'h2)   ? CMD_PRECHARGE :
    (strobes == 3'h6)   ? CMD_BURST_TERM :
    (strobes == 3'h1)   ? CMD_REFRESH :
                          CMD_LOAD_MODE;

  wire is_act      = (dec_cmd == CMD_ACTIVATE);
  wire is_rw       = (dec_cmd == CMD_READ) || (dec_cmd == CMD_WRITE);
  wire is_pre      = (dec_cmd == CMD_PRECHARGE);
  wire is_pre_all  = is_pre && i_cmd.auto_precharge_address_bit;
  wire is_quiet    = (dec_cmd == CMD_INHIBIT) || (dec_cmd == CMD_NOP);
  wire is_all_cmd  = (dec_cmd == CMD_REFRESH) || (dec_cmd == CMD_LOAD_MODE);

  wire cke_steady  = cke_prev && i_cke;
  wire dev_normal  = (dev_state == DEV_NORMAL);
  wire dev_locked  = (dev_state == DEV_REFRESH) || (dev_state == DEV_MODE) ||
                     (dev_state == DEV_PRE_ALL);
  wire rules_on    = cke_steady && dev_normal;

  bank_state_t tgt_state;
  assign tgt_state = o_bank_state[i_cmd.bank];

  logic [NUM_BANKS-1:0] bank_idle;
  logic [NUM_BANKS-1:0] bank_unprechargeable;
  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : g_scan
    assign bank_idle[g] = (o_bank_state[g] == BANK_IDLE);
    assign bank_unprechargeable[g] = o_bank_state[g] inside
      {BANK_ACTIVATING, BANK_READ_AP, BANK_WRITE_AP};
  end
  wire all_idle = &bank_idle;

  wire tgt_busy = tgt_state inside
    {BANK_ACTIVATING, BANK_PRECHARGING, BANK_READ_AP, BANK_WRITE_AP};
  wire tgt_open = tgt_state inside {BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE};
  bank_state_t last_state;
  assign last_state = o_bank_state[last_bank];
  wire burst_live = last_state inside {BANK_READ, BANK_WRITE};

  // Commands the controller should never send; refused ones change no state
  wire viol_busy_bank = !is_pre_all && (is_act || is_rw || is_pre) && tgt_busy;
  wire viol_locked    = dev_locked && !is_quiet;
  wire viol_not_idle  = is_all_cmd && !all_idle;
  wire viol_pre_all   = is_pre_all && (|bank_unprechargeable);
  wire viol_term      = (dec_cmd == CMD_BURST_TERM) && !burst_live;
  wire viol_sequence  = (is_act && !bank_idle[i_cmd.bank]) ||
                        (is_rw && !tgt_open && !tgt_busy);
  wire viol_now = cke_steady && (viol_busy_bank || viol_locked || viol_not_idle ||
                  viol_pre_all || viol_term || (dev_normal && viol_sequence));
  wire take     = rules_on && !viol_now;

  wire sr_entry = cke_prev && !i_cke && dev_normal && (dec_cmd == CMD_REFRESH) &&
                  all_idle;

  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : g_bank
    wire       hit = (i_cmd.bank == BANK_W'(g));
    bank_req_t req;
    assign req.act  = take && is_act && hit;
    assign req.rd   = take && (dec_cmd == CMD_READ) && hit;
    assign req.wr   = take && (dec_cmd == CMD_WRITE) && hit;
    assign req.pre  = take && is_pre && (hit || is_pre_all);
    assign req.ap   = i_cmd.auto_precharge_address_bit;
    assign req.stop = take && (dec_cmd == CMD_BURST_TERM) &&
                      (last_bank == BANK_W'(g));
    assign req.intr = take && is_rw && !hit;

    sdram_bank_tracker #(
      .ACT_CYC   (ACT_CYC),
      .PRE_CYC   (PRE_CYC),
      .BURST_LEN (BURST_LEN)
    ) u_bank (
      .i_clock  (i_clock),
      .i_rst_n  (i_rst_n),
      .i_clk_en (i_clk_en),
      .i_req    (req),
      .o_state  (o_bank_state[g])
    );
  end

  always_comb
  begin
    next_dev_state = dev_state;
    next_dev_cnt   = (dev_cnt == '0) ? dev_cnt : dev_cnt - CNT_W'(1);
    case (dev_state)
      DEV_NORMAL:
        if (sr_entry)
          next_dev_state = DEV_SELF_REF;
        else if (take && dec_cmd == CMD_REFRESH)
        begin
          next_dev_state = DEV_REFRESH;
          next_dev_cnt   = REF_LOAD;
        end
        else if (take && dec_cmd == CMD_LOAD_MODE)
        begin
          next_dev_state = DEV_MODE;
          next_dev_cnt   = MRD_LOAD;
        end
        else if (take && is_pre_all)
        begin
          next_dev_state = DEV_PRE_ALL;
          next_dev_cnt   = PRE_LOAD;
        end
      DEV_REFRESH, DEV_MODE, DEV_PRE_ALL, DEV_EXIT_WAIT:
        if (dev_cnt == '0)
          next_dev_state = DEV_NORMAL;
      DEV_SELF_REF:
        if (i_cke)
        begin
          next_dev_state = DEV_EXIT_WAIT;
          next_dev_cnt   = XSR_LOAD;
        end
      default:
        next_dev_state = DEV_NORMAL;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cke_prev  <= 1'b0;
      dev_state <= DEV_NORMAL;
      dev_cnt   <= '0;
      last_bank <= '0;
    end
    else if (i_clk_en)
    begin
      cke_prev  <= i_cke;
      dev_state <= next_dev_state;
      dev_cnt   <= next_dev_cnt;
      if (take && is_rw)
        last_bank <= i_cmd.bank;
    end
  end

  // Outputs are registered at the edge that caused them
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cmd          <= CMD_INHIBIT;
      o_all_idle     <= 1'b1;
      o_device_busy  <= 1'b0;
      o_rules_active <= 1'b0;
      o_violation    <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_cmd          <= dec_cmd;
      o_all_idle     <= all_idle;
      o_device_busy  <= (next_dev_state != DEV_NORMAL);
      o_rules_active <= rules_on;
      o_violation    <= viol_now;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence refresh_taken;
    i_clk_en && take && dec_cmd == CMD_REFRESH;
  endsequence
  sequence locked_ends;
    i_clk_en && dev_locked && dev_cnt == '0;
  endsequence

  AST_INHIBIT_DECODE: assert property (
    (i_clk_en && i_cmd.cs_n) |=> o_cmd == CMD_INHIBIT)
    else $error("Select high not decoded as inhibit");
  AST_WRITE_DECODE: assert property (
    (i_clk_en && !i_cmd.cs_n && strobes == 3'h4) |=> o_cmd == CMD_WRITE)
    else $error("Write strobes not decoded as write");
  AST_GATE_OFF: assert property (
    (i_clk_en && !cke_prev) |=> !o_rules_active)
    else $error("Tracking active without steady clock gate");
  AST_REFRESH_HOLD: assert property (
    refresh_taken |=> o_device_busy [*2])
    else $error("Refresh did not hold the device busy");
  AST_BUSY_RELEASE: assert property (
    locked_ends |=> !o_device_busy)
    else $error("Device stayed busy after its delay");
  AST_LOCKED_REFUSE: assert property (
    (i_clk_en && cke_steady && dev_locked && dec_cmd == CMD_ACTIVATE) |=> o_violation)
    else $error("Command during locked state not flagged");
  AST_ALL_IDLE_REQ: assert property (
    (i_clk_en && cke_steady && dev_normal && dec_cmd == CMD_REFRESH && !all_idle &&
     o_bank_state[0] inside {BANK_IDLE, BANK_ROW_ACTIVE})
      |=> o_violation ##0 o_bank_state[0] == $past(o_bank_state[0]))
    else $error("Refresh with open bank not refused");
  AST_PRE_ALL: assert property (
    (i_clk_en && take && is_pre_all && o_bank_state[0] == BANK_ROW_ACTIVE)
      |=> o_bank_state[0] == BANK_PRECHARGING && o_device_busy)
    else $error("Precharge-all did not precharge bank 0");
  AST_ALT_BANK: assert property (
    (i_clk_en && take && dec_cmd == CMD_READ && i_cmd.bank == 2'h1 &&
     o_bank_state[0] inside {BANK_READ, BANK_WRITE} &&
     o_bank_state[1] == BANK_ROW_ACTIVE)
      |=> o_bank_state[1] inside {BANK_READ, BANK_READ_AP})
    else $error("Read to bank 1 during bank 0 burst refused");
endmodule

//--- hdl/sdram_bank_tracker.sv
// State tracker of one SDRAM bank with its delay counter
`timescale 1ns/1ps
module sdram_bank_tracker #(
  parameter int ACT_CYC   = sdram_legality_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC,
  parameter int PRE_CYC   = sdram_legality_pkg::PRECHARGE_PERIOD_CYC,
  parameter int BURST_LEN = sdram_legality_pkg::BURST_LEN_DEFAULT
) (
  input  wire logic                            i_clock,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_clk_en,
  input  wire sdram_legality_pkg::bank_req_t   i_req,
  output sdram_legality_pkg::bank_state_t      o_state
);
  import sdram_legality_pkg::*;

  if (ACT_CYC < 1 || ACT_CYC > 255 || PRE_CYC < 1 || PRE_CYC > 255 ||
      BURST_LEN < 1 || BURST_LEN > 255)
  begin : g_bad_param
    $error("Bank tracker counts must lie in 1..255");
  end

  localparam logic [CNT_W-1:0] ACT_LOAD   = CNT_W'(ACT_CYC - 1);
  localparam logic [CNT_W-1:0] PRE_LOAD   = CNT_W'(PRE_CYC - 1);
  localparam logic [CNT_W-1:0] BURST_LOAD = CNT_W'(BURST_LEN - 1);

  bank_state_t      next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  wire              cnt_done = (cnt == '0);

  always_comb
  begin
    next_state = o_state;
    next_cnt   = cnt_done ? cnt : cnt - CNT_W'(1);
    case (o_state)
      BANK_IDLE:
        if (i_req.act)
        begin
          next_state = BANK_ACTIVATING;
          next_cnt   = ACT_LOAD;
        end
      BANK_ACTIVATING:
        if (cnt_done)
          next_state = BANK_ROW_ACTIVE;
      BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE:
        if (i_req.rd || i_req.wr)
        begin
          if (i_req.rd)
            next_state = i_req.ap ? BANK_READ_AP : BANK_READ;
          else
            next_state = i_req.ap ? BANK_WRITE_AP : BANK_WRITE;
          next_cnt = BURST_LOAD;
        end
        else if (i_req.pre)
        begin
          next_state = BANK_PRECHARGING;
          next_cnt   = PRE_LOAD;
        end
        else if (o_state != BANK_ROW_ACTIVE && (i_req.stop || i_req.intr || cnt_done))
          next_state = BANK_ROW_ACTIVE;
      BANK_READ_AP, BANK_WRITE_AP:
        // Burst end or a burst to another bank starts the own precharge
        if (i_req.intr || cnt_done)
        begin
          next_state = BANK_PRECHARGING;
          next_cnt   = PRE_LOAD;
        end
      BANK_PRECHARGING:
        if (cnt_done)
          next_state = BANK_IDLE;
      default:
        next_state = BANK_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_state <= BANK_IDLE;
      cnt     <= '0;
    end
    else if (i_clk_en)
    begin
      o_state <= next_state;
      cnt     <= next_cnt;
    end
  end

  // Checking helper: enabled edges spent in the current state
  logic [CNT_W-1:0] dwell;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dwell <= '0;
    else if (i_clk_en)
      dwell <= (next_state != o_state) ? '0 : dwell + CNT_W'(1);
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_ACT_ENTRY: assert property (
    (i_clk_en && i_req.act && o_state == BANK_IDLE) |=> o_state == BANK_ACTIVATING)
    else $error("Activate to idle bank did not start activating");
  AST_ACT_DWELL: assert property (
    (i_clk_en && o_state == BANK_ACTIVATING && next_state == BANK_ROW_ACTIVE)
      |-> dwell == ACT_LOAD)
    else $error("Activating state length differs from delay");
  AST_PRE_DWELL: assert property (
    (i_clk_en && o_state == BANK_PRECHARGING && next_state == BANK_IDLE)
      |-> dwell == PRE_LOAD)
    else $error("Precharging state length differs from period");
  AST_PRE_IDLE: assert property (
    (i_clk_en && i_req.pre && o_state == BANK_IDLE) |=> o_state == BANK_IDLE)
    else $error("Precharge changed an idle bank");
  AST_STOP: assert property (
    (i_clk_en && i_req.stop && !i_req.rd && !i_req.wr && !i_req.pre &&
     o_state inside {BANK_READ, BANK_WRITE}) |=> o_state == BANK_ROW_ACTIVE)
    else $error("Burst terminate did not end the burst");
  AST_AP_INTR: assert property (
    (i_clk_en && i_req.intr && o_state inside {BANK_READ_AP, BANK_WRITE_AP})
      |=> o_state == BANK_PRECHARGING)
    else $error("Interrupted auto-precharge burst did not precharge");
  AST_AP_START: assert property (
    (i_clk_en && i_req.rd && i_req.ap && o_state == BANK_ROW_ACTIVE)
      |=> o_state == BANK_READ_AP)
    else $error("Read with auto precharge not tracked");
endmodule

//--- hdl/sdram_legality_pkg.sv
// Shared types and constants for the SDRAM bank command legality tracker
package sdram_legality_pkg;

  localparam int NUM_BANKS                    = 4;
  localparam int BANK_W                       = 2;
  localparam int CNT_W                        = 8;
  localparam int CLOCK_PERIOD_NS              = 4;
  localparam int PRECHARGE_PERIOD_NS          = 18;
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS  = 18;
  localparam int REFRESH_CYCLE_NS             = 60;
  localparam int SELF_REFRESH_EXIT_TIME_NS    = 70;
  localparam int MODE_REGISTER_DELAY_CYC      = 2;
  localparam int BURST_LEN_DEFAULT            = 4;

  // Least times round up to whole cycles
  localparam int PRECHARGE_PERIOD_CYC =
    (PRECHARGE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ACTIVATE_TO_COLUMN_DELAY_CYC =
    (ACTIVATE_TO_COLUMN_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int REFRESH_CYCLE_CYC =
    (REFRESH_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_TIME_CYC =
    (SELF_REFRESH_EXIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [2:0] {
    BANK_IDLE        = 3'h0,
    BANK_ACTIVATING  = 3'h1,
    BANK_ROW_ACTIVE  = 3'h2,
    BANK_READ        = 3'h3,
    BANK_WRITE       = 3'h4,
    BANK_READ_AP     = 3'h5,
    BANK_WRITE_AP    = 3'h6,
    BANK_PRECHARGING = 3'h7
  } bank_state_t;

  typedef enum logic [2:0] {
    DEV_NORMAL    = 3'h0,
    DEV_REFRESH   = 3'h1,
    DEV_MODE      = 3'h2,
    DEV_PRE_ALL   = 3'h3,
    DEV_SELF_REF  = 3'h4,
    DEV_EXIT_WAIT = 3'h5
  } dev_state_t;

  typedef enum logic [3:0] {
    CMD_INHIBIT    = 4'h0,
    CMD_NOP        = 4'h1,
    CMD_ACTIVATE   = 4'h2,
    CMD_READ       = 4'h3,
    CMD_WRITE      = 4'h4,
    CMD_BURST_TERM = 4'h5,
    CMD_PRECHARGE  = 4'h6,
    CMD_REFRESH    = 4'h7,
    CMD_LOAD_MODE  = 4'h8
  } cmd_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic              auto_precharge_address_bit;
  } cmd_pins_t;

  typedef struct packed {
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic ap;
    logic stop;
    logic intr;
  } bank_req_t;

endpackage

//--- testbench/sdram_bank_command_legality_tb.sv
// Self-checking bench for the bank command legality tracker
`timescale 1ns/1ps
module sdram_bank_command_legality_tb;
  import sdram_legality_pkg::*;

  // Short counts keep the run brief
  localparam int ACT = 2;
  localparam int PRE = 2;
  localparam int REF = 3;
  localparam int MRD = 1;
  localparam int BL  = 2;
  localparam int XSR = 2;

  logic        i_clock;
  logic        i_rst_n;
  logic        i_clk_en;
  logic        i_cke;
  logic        ap;
  logic        all_idle;
  logic        busy;
  logic        rules_on;
  logic        viol;
  logic [1:0]  bank;
  logic [1:0]  b;
  logic [1:0]  ob;
  logic [2:0]  fill;
  cmd_t        kind;
  cmd_t        cmd_seen;
  cmd_pins_t   pins;
  bank_state_t st [NUM_BANKS];
  int          error_cnt;
  int          compares;
  int          seed;
  int          i;

  sdram_ctrl_model ctrl_u (
    .i_kind (kind),
    .i_bank (bank),
    .i_ap   (ap),
    .i_fill (fill),
    .o_pins (pins)
  );

  sdram_bank_command_legality #(
    .ACT_CYC   (ACT),
    .PRE_CYC   (PRE),
    .REF_CYC   (REF),
    .MRD_CYC   (MRD),
    .XSR_CYC   (XSR),
    .BURST_LEN (BL)
  ) dut_u (
    .i_clock        (i_clock),
    .i_rst_n        (i_rst_n),
    .i_clk_en       (i_clk_en),
    .i_cke          (i_cke),
    .i_cmd          (pins),
    .o_bank_state   (st),
    .o_cmd          (cmd_seen),
    .o_all_idle     (all_idle),
    .o_device_busy  (busy),
    .o_rules_active (rules_on),
    .o_violation    (viol)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Called just after an edge; returns just after the edge that takes it
  task automatic drive(input cmd_t k, input logic [1:0] bk, input logic a);
    kind = k;
    bank = bk;
    ap   = a;
    fill = 3'($random(seed));
    @(posedge i_clock);
    #1;
  endtask

  task automatic span(input logic [1:0] bk, input bank_state_t s, input int n);
    for (int j = 0; j < n; j++)
    begin
      chk(st[bk], s);
      drive(CMD_NOP, bk, 1'b0);
    end
  endtask

  task automatic busy_for(input int n);
    for (int j = 0; j < n; j++)
    begin
      chk(busy, 1'b1);
      drive(CMD_NOP, 2'h0, 1'b0);
    end
    chk(busy, 1'b0);
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  initial
  begin
    #20000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    seed      = 45;
    error_cnt = 0;
    compares  = 0;
    i_rst_n   = 1'b0;
    i_clk_en  = 1'b1;
    i_cke     = 1'b1;
    kind      = CMD_NOP;
    bank      = 2'h0;
    ap        = 1'b0;
    fill      = 3'h0;
    repeat (6) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    chk(cmd_seen, CMD_INHIBIT);
    chk(all_idle, 1'b1);
    chk(rules_on, 1'b0);
    // First edge after release never takes a command
    drive(CMD_NOP, 2'h0, 1'b0);
    b  = 2'($random(seed));
    ob = b + 2'h1;

    drive(CMD_ACTIVATE, b, 1'b0);
    chk(cmd_seen, CMD_ACTIVATE);
    chk(st[b], BANK_ACTIVATING);
    i_clk_en = 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    chk(st[b], BANK_ACTIVATING);
    i_clk_en = 1'b1;
    drive(CMD_ACTIVATE, b, 1'b0);
    chk(viol, 1'b1);
    span(b, BANK_ACTIVATING, ACT - 1);
    chk(st[b], BANK_ROW_ACTIVE);
    // No burst has run yet, so a terminate has nothing to stop
    drive(CMD_BURST_TERM, b, 1'b0);
    chk(viol, 1'b1);
    drive(CMD_REFRESH, b, 1'b0);
    chk(viol, 1'b1);
    chk(st[b], BANK_ROW_ACTIVE);
    chk(busy, 1'b0);
    $display("test activate done");

    drive(CMD_READ, b, 1'b0);
    chk(st[b], BANK_READ);
    drive(CMD_BURST_TERM, b, 1'b0);
    chk(st[b], BANK_ROW_ACTIVE);
    drive(CMD_WRITE, b, 1'b0);
    span(b, BANK_WRITE, BL);
    chk(st[b], BANK_ROW_ACTIVE);
    drive(CMD_READ, b, 1'b1);
    chk(st[b], BANK_READ_AP);
    drive(CMD_ACTIVATE, ob, 1'b0);
    chk(viol, 1'b0);
    chk(st[ob], BANK_ACTIVATING);
    span(b, BANK_READ_AP, BL - 1);
    span(b, BANK_PRECHARGING, PRE);
    chk(st[b], BANK_IDLE);
    chk(st[ob], BANK_ROW_ACTIVE);
    drive(CMD_PRECHARGE, ob, 1'b0);
    span(ob, BANK_PRECHARGING, PRE);
    chk(st[ob], BANK_IDLE);
    drive(CMD_PRECHARGE, ob, 1'b0);
    chk(viol, 1'b0);
    chk(st[ob], BANK_IDLE);
    drive(CMD_READ, ob, 1'b0);
    chk(viol, 1'b1);
    $display("test bursts done");

    chk(all_idle, 1'b1);
    drive(CMD_REFRESH, b, 1'b0);
    drive(CMD_ACTIVATE, b, 1'b0);
    chk(viol, 1'b1);
    chk(st[b], BANK_IDLE);
    busy_for(REF - 1);
    drive(CMD_LOAD_MODE, b, 1'b0);
    busy_for(MRD);
    chk(all_idle, 1'b1);
    drive(CMD_ACTIVATE, b, 1'b0);
    drive(CMD_ACTIVATE, ob, 1'b0);
    // Both banks still activating: precharge-all must be refused
    drive(CMD_PRECHARGE, b, 1'b1);
    chk(viol, 1'b1);
    chk(busy, 1'b0);
    span(ob, BANK_ACTIVATING, ACT - 1);
    drive(CMD_READ, b, 1'b1);
    drive(CMD_READ, ob, 1'b0);
    chk(st[b], BANK_PRECHARGING);
    chk(st[ob], BANK_READ);
    span(b, BANK_PRECHARGING, PRE);
    chk(st[b], BANK_IDLE);
    drive(CMD_PRECHARGE, b, 1'b1);
    chk(st[ob], BANK_PRECHARGING);
    busy_for(PRE);
    chk(st[ob], BANK_IDLE);
    $display("test device states done");

    // Clock gate low on the previous edge blocks the next command
    i_cke = 1'b0;
    drive(CMD_NOP, b, 1'b0);
    i_cke = 1'b1;
    drive(CMD_ACTIVATE, b, 1'b0);
    chk(st[b], BANK_IDLE);
    chk(rules_on, 1'b0);
    drive(CMD_ACTIVATE, b, 1'b0);
    span(b, BANK_ACTIVATING, ACT);
    for (i = 0; i < 24; i++)
    begin
      drive(($random(seed) & 1) ? CMD_NOP : CMD_INHIBIT, 2'($random(seed)),
            1'($random(seed)));
      chk(st[b], BANK_ROW_ACTIVE);
      chk(viol, 1'b0);
    end
    $display("test clock gate and idle commands done");

    // Self refresh needs every bank idle; exit wait ignores commands
    drive(CMD_PRECHARGE, b, 1'b0);
    span(b, BANK_PRECHARGING, PRE);
    i_cke = 1'b0;
    drive(CMD_REFRESH, b, 1'b0);
    drive(CMD_ACTIVATE, b, 1'b0);
    chk(busy, 1'b1);
    chk(viol, 1'b0);
    chk(st[b], BANK_IDLE);
    i_cke = 1'b1;
    drive(CMD_NOP, b, 1'b0);
    drive(CMD_ACTIVATE, b, 1'b0);
    chk(st[b], BANK_IDLE);
    chk(viol, 1'b0);
    busy_for(XSR - 1);
    drive(CMD_ACTIVATE, b, 1'b0);
    chk(st[b], BANK_ACTIVATING);
    $display("test self refresh done");
    complete_run();
  end
endmodule

//--- testbench/sdram_ctrl_model.sv
// Memory controller stand-in that turns a command kind into command pins
`timescale 1ns/1ps
module sdram_ctrl_model (
  input  wire sdram_legality_pkg::cmd_t   i_kind,
  input  wire logic [1:0]                 i_bank,
  input  wire logic                       i_ap,
  input  wire logic [2:0]                 i_fill,
  output sdram_legality_pkg::cmd_pins_t   o_pins
);
  import sdram_legality_pkg::*;

  // Order: select, row, column, write strobe, all active low
  logic [3:0] strobes;

  assign o_pins = {strobes, i_bank, i_ap};

  always_comb
  begin
    case (i_kind)
      // Unselected strobes wander so a stale level never looks valid
      CMD_INHIBIT:    strobes = {1'b1, i_fill};
      CMD_ACTIVATE:   strobes = 4'h3;
      CMD_READ:       strobes = 4'h5;
      CMD_WRITE:      strobes = 4'h4;
      CMD_BURST_TERM: strobes = 4'h6;
      CMD_PRECHARGE:  strobes = 4'h2;
      CMD_REFRESH:    strobes = 4'h1;
      CMD_LOAD_MODE:  strobes = 4'h0;
      default:        strobes = 4'h7;
    endcase
  end
endmodule
